// *** hdl/dac_pkg.sv ***
// shared constants and types of the dual converter control block
package dac_pkg;
  // ------------------------------------------------------------
  // word layout
  // ------------------------------------------------------------
  localparam int WORD_W = 10;
  localparam int FIFO_DEPTH = 32;
  localparam logic [WORD_W-1:0] MID_CODE = 10'h200;
  localparam logic [WORD_W-1:0] MAX_CODE = 10'h3ff;
  localparam logic [WORD_W-1:0] ZERO_WORD = 10'h000;
  // ------------------------------------------------------------
  // offset correction
  // ------------------------------------------------------------
  localparam logic [5:0] CAL_CYCLES = 6'h22;
  localparam logic [5:0] CAL_SAMPLES = 6'h20;
  localparam int CAL_SHIFT = 5;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int LIGHT_WAKE_NS = 800;
  localparam int LIGHT_WAKE_CYC = LIGHT_WAKE_NS * CLK_MHZ / 1000;
  localparam int DEEP_WAKE_NS = 1000000;
  localparam int DEEP_WAKE_CYC = DEEP_WAKE_NS / 1000 * CLK_MHZ;
  // entries queued before the oldest is due on a rising edge
  localparam int LAT_FILL = 3;
  localparam logic [17:0] WAKE_ZERO = 18'h00000;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [WORD_W-1:0] first;
    logic [WORD_W-1:0] second;
  } dac_pair_type;
  typedef enum logic [1:0] {
    DAC_RUN,
    DAC_LIGHT,
    DAC_DEEP,
    DAC_WAKE
  } dac_power_type;
endpackage

// *** hdl/dac_control.sv ***
// digital control and output logic of the dual converter
// What this block does
// - both channels sample on the falling edge of the shared converter clock.
// - parallel mode drives each channel on its own bus simultaneously.
// - multiplexed mode interleaves both onto first bus, second bus held low.
// - offset trigger rising edge starts per-channel correction lasting 34 cycles.
// - correction averages 32 conversions, later results subtract its deviation from midscale.
// - format low gives offset binary, high gives two's complement.
// - format may change anytime; one or two words may be miscoded.
// - both sleep inputs low converts; light request alone enters standby.
// - after light request drops, normal operation resumes within 800 ns.
// - deep request powers down; recovery under 1 ms after it drops.
// - with both requests high, deep sleep wins.
// - bus bit zero is the result LSB, bit nine the MSB.
// - parallel words appear just after each converter clock rising edge.
// - multiplexed strobe high marks first channel, low marks second channel.
// - multiplexed strobe rises on second-to-first change, falls on reverse.
// - parallel strobe rises each time the output data changes.
// - results appear 2.5 clocks after sampling; first mux word likewise.
// - second channel mux word appears 3 clocks after sampling.
`timescale 1ns/1ps

// ------------------------------------------------------------
// sample fifo
// ------------------------------------------------------------
module dac_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  wire do_wr = in_valid && in_ready;
  wire do_rd = out_valid && out_ready;
  assign in_ready = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data = mem_r[rd_r];
  assign level = cnt_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (do_wr) wr_r <= wr_r + 1'b1;
      if (do_rd) rd_r <= rd_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

  always_ff @(posedge clk) begin
    if (do_wr) mem_r[wr_r] <= in_data;
  end

  fifo_no_overrun_a: assert property (@(posedge clk) disable iff (!reset_n)
    cnt_r <= (AW+1)'(DEPTH))
    else $error("fifo level beyond depth");
endmodule

// ------------------------------------------------------------
// top
// ------------------------------------------------------------
module dac_control #(
  parameter int WORD_W = dac_pkg::WORD_W,
  parameter int FIFO_DEPTH = dac_pkg::FIFO_DEPTH,
  parameter int DEEP_WAKE_CYC = dac_pkg::DEEP_WAKE_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic conv_clk,
  input wire logic [WORD_W-1:0] first_sample,
  input wire logic [WORD_W-1:0] second_sample,
  input wire logic bus_layout_select,
  input wire logic offset_correct_trigger,
  input wire logic output_coding_select,
  input wire logic light_sleep_request,
  input wire logic deep_sleep_request,
  output logic [WORD_W-1:0] first_channel_bus,
  output logic [WORD_W-1:0] second_channel_bus,
  output logic channel_strobe,
  output logic converting,
  output logic correcting,
  output logic sample_dropped
);
  localparam int SYNC_W = 2 * WORD_W + 6;
  localparam logic [17:0] LIGHT_CYC = 18'(dac_pkg::LIGHT_WAKE_CYC);
  localparam logic [17:0] DEEP_CYC = 18'(DEEP_WAKE_CYC);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic ck_d_r;
  logic trig_d_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
      ck_d_r <= 1'b0;
      trig_d_r <= 1'b0;
    end else begin
      sync1_r <= {conv_clk, offset_correct_trigger, output_coding_select,
                  light_sleep_request, deep_sleep_request,
                  bus_layout_select, first_sample, second_sample};
      sync2_r <= sync1_r;
      ck_d_r <= sync2_r[SYNC_W-1];
      trig_d_r <= sync2_r[SYNC_W-2];
    end
  end

  wire ck_s = sync2_r[SYNC_W-1];
  wire trig_s = sync2_r[SYNC_W-2];
  wire fmt_s = sync2_r[SYNC_W-3];
  wire light_s = sync2_r[SYNC_W-4];
  wire deep_s = sync2_r[SYNC_W-5];
  wire par_s = sync2_r[SYNC_W-6];
  wire [WORD_W-1:0] raw_first = sync2_r[2*WORD_W-1:WORD_W];
  wire [WORD_W-1:0] raw_second = sync2_r[WORD_W-1:0];
  wire ck_fall = ck_d_r && !ck_s;
  wire ck_rise = !ck_d_r && ck_s;
  wire trig_rise = trig_s && !trig_d_r;

  // ------------------------------------------------------------
  // power states
  // ------------------------------------------------------------
  dac_pkg::dac_power_type pwr_r;
  dac_pkg::dac_power_type pwr_nxt;
  logic [17:0] wake_r;
  logic [17:0] wake_nxt;
  logic run_r;
  // a deep request seen during wake restarts the whole deep recovery; a light one reloads the light count
  always_comb begin
    pwr_nxt = pwr_r;
    wake_nxt = wake_r;
    if (deep_s) begin
      pwr_nxt = dac_pkg::DAC_DEEP;
      wake_nxt = DEEP_CYC;
    end else if (light_s) begin
      pwr_nxt = dac_pkg::DAC_LIGHT;
      if (pwr_r != dac_pkg::DAC_DEEP) wake_nxt = LIGHT_CYC;
    end else begin
      unique case (pwr_r)
        dac_pkg::DAC_RUN: pwr_nxt = dac_pkg::DAC_RUN;
        dac_pkg::DAC_LIGHT,
        dac_pkg::DAC_DEEP: begin
          pwr_nxt = dac_pkg::DAC_WAKE;
          wake_nxt = wake_r - 18'h00001;
        end
        dac_pkg::DAC_WAKE: begin
          if (wake_r <= 18'h00001) begin
            pwr_nxt = dac_pkg::DAC_RUN;
            wake_nxt = dac_pkg::WAKE_ZERO;
          end else begin
            wake_nxt = wake_r - 18'h00001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pwr_r <= dac_pkg::DAC_RUN;
      wake_r <= dac_pkg::WAKE_ZERO;
      run_r <= 1'b1;
    end else begin
      pwr_r <= pwr_nxt;
      wake_r <= wake_nxt;
      run_r <= pwr_nxt == dac_pkg::DAC_RUN;
    end
  end

  logic [7:0] light_wait_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) light_wait_r <= '0;
    else if (light_s || deep_s || run_r) light_wait_r <= '0;
    else if (light_wait_r != '0 || wake_r == LIGHT_CYC)
      light_wait_r <= light_wait_r + 8'h01;
  end

  deep_priority_a: assert property (@(posedge clk) disable iff (!reset_n)
    deep_s |=> pwr_r == dac_pkg::DAC_DEEP)
    else $error("deep request did not win");
  light_wake_a: assert property (@(posedge clk) disable iff (!reset_n)
    18'(light_wait_r) <= LIGHT_CYC)
    else $error("light sleep recovery too slow");
  wake_bound_a: assert property (@(posedge clk) disable iff (!reset_n)
    wake_r <= DEEP_CYC || wake_r <= LIGHT_CYC)
    else $error("wake counter out of range");

  // ------------------------------------------------------------
  // offset correction
  // ------------------------------------------------------------
  logic cal_r;
  logic [5:0] cal_cnt_r;
  logic [14:0] acc_first_r;
  logic [14:0] acc_second_r;
  logic [WORD_W-1:0] avg_first_r;
  logic [WORD_W-1:0] avg_second_r;
  wire cal_take = cal_r && ck_fall && run_r;
  wire cal_acc = cal_take && cal_cnt_r < dac_pkg::CAL_SAMPLES;
  wire cal_done = cal_take && cal_cnt_r == dac_pkg::CAL_CYCLES - 6'h01;
  wire [14:0] acc_first_nxt = acc_first_r + 15'(raw_first);
  wire [14:0] acc_second_nxt = acc_second_r + 15'(raw_second);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cal_r <= 1'b0;
      cal_cnt_r <= '0;
      acc_first_r <= '0;
      acc_second_r <= '0;
      avg_first_r <= dac_pkg::MID_CODE;
      avg_second_r <= dac_pkg::MID_CODE;
    end else if (trig_rise) begin
      cal_r <= 1'b1;
      cal_cnt_r <= '0;
      acc_first_r <= '0;
      acc_second_r <= '0;
    end else if (cal_take) begin
      cal_cnt_r <= cal_cnt_r + 6'h01;
      if (cal_acc) begin
        acc_first_r <= acc_first_nxt;
        acc_second_r <= acc_second_nxt;
      end
      if (cal_done) begin
        cal_r <= 1'b0;
        avg_first_r <= acc_first_r[dac_pkg::CAL_SHIFT +: WORD_W];
        avg_second_r <= acc_second_r[dac_pkg::CAL_SHIFT +: WORD_W];
      end
    end
  end

  // removes the measured deviation from midscale, clamped to code range
  function automatic logic [WORD_W-1:0] dac_correct(
    input logic [WORD_W-1:0] raw,
    input logic [WORD_W-1:0] avg
  );
    logic [11:0] t;
    t = 12'(raw) + 12'(dac_pkg::MID_CODE) - 12'(avg);
    if (t[11]) dac_correct = dac_pkg::ZERO_WORD;
    else if (t[10]) dac_correct = dac_pkg::MAX_CODE;
    else dac_correct = t[WORD_W-1:0];
  endfunction

  cal_length_a: assert property (@(posedge clk) disable iff (!reset_n)
    cal_r |-> cal_cnt_r < dac_pkg::CAL_CYCLES)
    else $error("correction ran past its length");
  cal_ends_a: assert property (@(posedge clk) disable iff (!reset_n)
    cal_done && !trig_rise |=> !cal_r && cal_cnt_r == dac_pkg::CAL_CYCLES)
    else $error("correction did not end on its last cycle");

  // ------------------------------------------------------------
  // sampling into the latency fifo
  // ------------------------------------------------------------
  dac_pkg::dac_pair_type push_word;
  dac_pkg::dac_pair_type pop_word;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;
  wire push = ck_fall && run_r;
  assign push_word.first = dac_correct(raw_first, avg_first_r);
  assign push_word.second = dac_correct(raw_second, avg_second_r);
  // the oldest word is due once two younger samples stand behind it
  wire due = fifo_level >= ($clog2(FIFO_DEPTH)+1)'(dac_pkg::LAT_FILL);
  wire pop = ck_rise && run_r && due && fifo_out_valid;

  dac_fifo #(
    .WIDTH($bits(dac_pkg::dac_pair_type)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(push_word),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(pop_word),
    .level(fifo_level)
  );

  sample_on_fall_a: assert property (@(posedge clk) disable iff (!reset_n)
    push |-> $past(ck_s) && !ck_s)
    else $error("sample taken off the falling edge");

  // ------------------------------------------------------------
  // output coding and bus layout
  // ------------------------------------------------------------
  logic [WORD_W-1:0] held_second_r;
  logic [WORD_W-1:0] first_bus_r;
  logic [WORD_W-1:0] second_bus_r;
  logic strobe_r;
  logic drop_r;
  logic mux_pending_r;
  // coding is applied when a word is popped, so a format change lands on the next popped word; a held mux second word keeps the old coding
  wire [WORD_W-1:0] fmt_mask = {fmt_s, {(WORD_W-1){1'b0}}};
  wire [WORD_W-1:0] coded_first = pop_word.first ^ fmt_mask;
  wire [WORD_W-1:0] coded_second = pop_word.second ^ fmt_mask;
  wire mux_second = ck_fall && !par_s && mux_pending_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      first_bus_r <= dac_pkg::ZERO_WORD;
      second_bus_r <= dac_pkg::ZERO_WORD;
      held_second_r <= dac_pkg::ZERO_WORD;
      strobe_r <= 1'b0;
      mux_pending_r <= 1'b0;
    end else if (pop) begin
      first_bus_r <= coded_first;
      second_bus_r <= par_s ? coded_second : dac_pkg::ZERO_WORD;
      held_second_r <= coded_second;
      strobe_r <= 1'b1;
      mux_pending_r <= !par_s;
    end else if (mux_second) begin
      first_bus_r <= held_second_r;
      second_bus_r <= dac_pkg::ZERO_WORD;
      strobe_r <= 1'b0;
      mux_pending_r <= 1'b0;
    end else if (ck_fall) begin
      strobe_r <= 1'b0;
      mux_pending_r <= 1'b0;
      if (!par_s) second_bus_r <= dac_pkg::ZERO_WORD;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) drop_r <= 1'b0;
    else drop_r <= push && !fifo_in_ready;
  end

  assign first_channel_bus = first_bus_r;
  assign second_channel_bus = second_bus_r;
  assign channel_strobe = strobe_r;
  assign converting = run_r;
  assign correcting = cal_r;
  assign sample_dropped = drop_r;

  strobe_marks_first_a: assert property (@(posedge clk) disable iff (!reset_n)
    pop |=> strobe_r && first_bus_r == $past(coded_first))
    else $error("first word not marked by a high strobe");
  mux_second_word_a: assert property (@(posedge clk) disable iff (!reset_n)
    mux_second |=> !strobe_r && first_bus_r == $past(held_second_r))
    else $error("second word not marked by a low strobe");
  mux_quiet_bus_a: assert property (@(posedge clk) disable iff (!reset_n)
    (pop || ck_fall) && !par_s |=> second_bus_r == dac_pkg::ZERO_WORD)
    else $error("second bus not low in multiplexed mode");
  coding_msb_a: assert property (@(posedge clk) disable iff (!reset_n)
    pop && fmt_s |=> first_bus_r[WORD_W-1] != $past(pop_word.first[WORD_W-1]))
    else $error("two's complement msb not inverted");
  parallel_both_a: assert property (@(posedge clk) disable iff (!reset_n)
    pop && par_s |=> second_bus_r == $past(coded_second))
    else $error("parallel second word missing");
endmodule

// *** tb/dac_host.sv ***
// host side model: converter clock pin and sample source
`timescale 1ns/1ps

// ------------------------------------------------------------
// converter clock and samples
// ------------------------------------------------------------
module dac_host #(
  parameter int HALF = 10
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [dac_pkg::WORD_W-1:0] next_first,
  input wire logic [dac_pkg::WORD_W-1:0] next_second,
  output logic conv_clk,
  output logic [dac_pkg::WORD_W-1:0] first_sample,
  output logic [dac_pkg::WORD_W-1:0] second_sample
);
  int cnt;
  // samples move only on the rising edge, half a period away from the
  // falling-edge sampling instant, so the synchroniser never sees them move
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 0;
      conv_clk <= 1'b0;
      first_sample <= '0;
      second_sample <= '0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      conv_clk <= ~conv_clk;
      if (!conv_clk) begin
        first_sample <= next_first;
        second_sample <= next_second;
      end
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// *** tb/dac_control_tb.sv ***
// self-checking testbench of the dual converter control block
`timescale 1ns/1ps

module dac_control_tb;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clk, reset_n, par, trig, fmt, light, deep, hold, chk_on;
  logic drop, drop_seen;
  logic conv_clk, conv_q, stb_q, stb, converting, correcting;
  logic [2:0] cf;
  logic [dac_pkg::WORD_W-1:0] nf, ns, fs, ss, fb, sb;
  logic [15:0] seed;
  int miscompares, n_compared, nwords, skip, ofs_f, ofs_s, cnt;
  dac_pkg::dac_pair_type hist[$];
  dac_pkg::dac_pair_type p;

  dac_host host (.clk(clk), .reset_n(reset_n), .next_first(nf),
    .next_second(ns), .conv_clk(conv_clk), .first_sample(fs),
    .second_sample(ss));

  dac_control #(.DEEP_WAKE_CYC(50)) DUT (.clk(clk), .reset_n(reset_n),
    .conv_clk(conv_clk), .first_sample(fs), .second_sample(ss),
    .bus_layout_select(par), .offset_correct_trigger(trig),
    .output_coding_select(fmt), .light_sleep_request(light),
    .deep_sleep_request(deep), .first_channel_bus(fb),
    .second_channel_bus(sb), .channel_strobe(stb),
    .converting(converting), .correcting(correcting),
    .sample_dropped(drop));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {1'b0, s[15:1]} ^ (s[0] ? 16'hb400 : 16'h0000);
  endfunction

  function automatic logic [9:0] exp_word(logic [9:0] raw, int ofs);
    int v;
    v = int'(raw) - ofs;
    if (v < 0) v = 0;
    if (v > 1023) v = 1023;
    return fmt ? {~v[9], v[8:0]} : v[9:0];
  endfunction

  task automatic cmp_word(string what, logic [9:0] e, logic [9:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic cmp_bit(string what, logic e, logic g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic run_words(int n);
    int t;
    t = nwords + n;
    repeat (n * 60) if (nwords < t) @(negedge clk);
    cmp_bit("words flowing", 1'b1, nwords >= t);
  endtask

  // drop both sleep requests and time the way back to converting
  task automatic wake(int lim);
    cnt = 0;
    light = 1'b0;
    deep = 1'b0;
    while (converting !== 1'b1 && cnt < 1000) begin
      @(negedge clk);
      cnt++;
    end
    cmp_bit("wake in time", 1'b1, cnt <= lim);
    hist.delete();
    chk_on = 1'b1;
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // clock, stimulus source, monitor
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(negedge clk) begin
    if (reset_n === 1'b1) seed <= lfsr(seed);
    if (!hold) begin
      nf <= seed[9:0];
      ns <= seed[15:6];
    end
  end

  // history is pushed three cycles late to line up with the synchroniser
  always @(negedge clk) begin
    conv_q <= conv_clk;
    stb_q <= stb;
    cf <= {cf[1:0], conv_q & ~conv_clk};
    if (reset_n === 1'b1 && drop !== 1'b0) drop_seen <= 1'b1;
    if (cf[2]) hist.push_back({fs, ss});
    if (chk_on && hist.size() > 3 && stb_q !== stb) begin
      if (skip > 0) begin
        skip--;
      end else if (stb) begin
        p = hist[hist.size()-3];
        cmp_word("first bus", exp_word(p.first, ofs_f), fb);
        cmp_word("second bus", par ? exp_word(p.second, ofs_s) : '0, sb);
        nwords++;
      end else if (!par) begin
        p = hist[hist.size()-4];
        cmp_word("mux second", exp_word(p.second, ofs_s), fb);
      end
    end
  end

  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    print_verdict();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    {par, trig, fmt, light, deep, hold, chk_on} = 7'h40;
    {conv_q, stb_q, cf} = 5'h00;
    drop_seen = 1'b0;
    seed = 16'h0020;
    nf = '0;
    ns = '0;
    reset_n = 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    chk_on = 1'b1;
    run_words(20);
    fmt = 1'b1;
    skip = 6;
    run_words(20);
    $display("test parallel done");
    par = 1'b0;
    skip = 6;
    run_words(20);
    fmt = 1'b0;
    skip = 6;
    run_words(10);
    $display("test multiplexed done");
    par = 1'b1;
    chk_on = 1'b0;
    hold = 1'b1;
    nf = 10'h20a;
    ns = 10'h1f0;
    repeat (80) @(negedge clk);
    trig = 1'b1;
    cnt = 0;
    repeat (1000) begin
      @(negedge clk);
      if (correcting === 1'b1) cnt++;
    end
    trig = 1'b0;
    cmp_bit("correction length", 1'b1, cnt >= 660 && cnt <= 700);
    ofs_f = 10;
    ofs_s = -16;
    nf = 10'h005;
    ns = 10'h3fa;
    skip = 6;
    chk_on = 1'b1;
    run_words(6);
    hold = 1'b0;
    run_words(20);
    $display("test correction done");
    chk_on = 1'b0;
    light = 1'b1;
    repeat (20) @(negedge clk);
    cmp_bit("light halts", 1'b0, converting);
    wake(206);
    run_words(10);
    chk_on = 1'b0;
    light = 1'b1;
    deep = 1'b1;
    repeat (20) @(negedge clk);
    cmp_bit("deep halts", 1'b0, converting);
    wake(60);
    run_words(10);
    cmp_bit("sample dropped", 1'b0, drop_seen);
    $display("test sleep done");
    print_verdict();
  end
endmodule
